// ### p7m_pkg.sv
// Purpose: Shared constants for the port 7 pin function selector
// Assumes: Four pins, 4-bit output-select fields
// Notes: Select codes 1x00..1x11 pick alternate outputs 0..3
`default_nettype none
package p7m_pkg;
    localparam int PIN_COUNT = 4;
    localparam int SEL_WIDTH = 4;
    // Field positions inside an output-select code
    localparam int SEL_ENABLE_BIT = 3;
    localparam int SEL_ALT_LSB = 0;
    localparam int SEL_ALT_WIDTH = 2;
    // Reset value of each select field: input only
    localparam logic [3:0] SEL_RESET = 4'h0;
    // Alternate output indices
    localparam logic [1:0] ALT_OUT0 = 2'h0;
    localparam logic [1:0] ALT_OUT1 = 2'h1;
    localparam logic [1:0] ALT_OUT2 = 2'h2;
    localparam logic [1:0] ALT_OUT3 = 2'h3;
    // Pin indices
    localparam int PIN_BIT0 = 0;
    localparam int PIN_BIT1 = 1;
    localparam int PIN_BIT2 = 2;
    localparam int PIN_BIT3 = 3;
    // Debug start-up states
    typedef enum logic [2:0]
    {
        DBG_WAIT = 3'b001,
        DBG_INACTIVE = 3'b010,
        DBG_ACTIVE = 3'b100
    } p7m_dbg_state_t;
endpackage
`default_nettype wire

// ### p7m_pin_select.sv
// Purpose: Output function selection and input routing for port 7 bits 0..3
// Assumes: Single 200 MHz clock; arst_n mirrors the power-on reset pin
// Notes: Pin inputs pass three flip-flops; last two must agree to update
//        Debug enable is latched once per reset from the settled debug-reset pin
//
// Behaviour
// [R1] Each pin output chosen by select code 1x00, 1x01 and onward.
// [R2] Hardware-owned output, bit 0 debug data out, overrides the select field.
// [R3] Bit 2 outputs: GPIO, analog mux bit 0, CAN4 transmit, CAN5 transmit.
// [R4] Bit 2 level feeds capture position 0 and boundary-scan data in.
// [R5] Bit 0 outputs: GPIO, timer 3 toggle, timer 6 toggle.
// [R6] Bit 0 level feeds service request 2 input 1 and CAN4 receive B.
// [R7] Bit 3 outputs: GPIO, analog mux bit 1, serial 1 out, serial 0 out.
// [R8] Bit 3 level feeds capture position 1, serial 1 input F, scan mode-select.
// [R9] Bit 1 outputs clock out and CAN4 transmit; feeds trap and debug break.
// [R10] Debug active only if debug reset pin high at power-on reset release.
// [R11] After activation the debug reset pin is driven low once by the outside.
// [R12] Outside holds debug reset low and test enable high in normal use.
// [R13] Factory test mode whenever test enable is not high.
// [R14] Input paths stay connected regardless of output selection.
// [R15] Select code with top bit clear leaves the pin undriven.
`timescale 1ns/1ps
`default_nettype none
module p7m_pin_select
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [15:0] output_select_field,
    input wire logic [3:0] gpio_out,
    input wire logic timer3_toggle_out,
    input wire logic timer6_toggle_out,
    input wire logic programmable_clock_out,
    input wire logic can_node4_tx,
    input wire logic can_node4_tx_alt,
    input wire logic can_node5_tx,
    input wire logic analog_mux_ctrl_bit0,
    input wire logic analog_mux_ctrl_bit1,
    input wire logic serial_ch1_data_out,
    input wire logic serial_ch0_data_out,
    input wire logic debug_tdo,
    input wire logic debug_tdo_en,
    input wire logic scan_pos_c_sel,
    input wire logic [3:0] pin_in,
    input wire logic debug_reset_pin,
    input wire logic factory_test_enable,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic [3:0] gpio_in,
    output logic ext_service_req2_in1,
    output logic can_node4_rx_b,
    output logic capture_unit_pos_in0,
    output logic capture_unit_pos_in1,
    output logic capture_unit_trap_in,
    output logic debug_break_in,
    output logic serial_ch1_data_in_f,
    output logic scan_tdi,
    output logic scan_tms,
    output logic debug_active,
    output logic debug_reset_req,
    output logic factory_test_mode
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        // Pad filters
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] level;
        logic [1:0] trst_s1;
        logic [1:0] trst_s2;
        logic [1:0] trst_s3;
        logic [1:0] trst_lvl;
        // Ones shift in after reset; top bit marks a real pin sample in stage 3
        logic [2:0] trst_fill;
        p7m_pkg::p7m_dbg_state_t dbg;
        logic [3:0] out;
        logic [3:0] oe_n;
    } p7m_state_t;

    p7m_state_t state;
    p7m_state_t next_state;
    logic [3:0] alt_value [4];

    // Decode one select field into its alternate index
    function automatic logic [1:0] alt_index(input logic [3:0] sel);
        alt_index = sel[p7m_pkg::SEL_ALT_LSB +: p7m_pkg::SEL_ALT_WIDTH];
    endfunction

    // ------------------------------------------------------------
    // Alternate output tables, indexed [pin][alternate]
    // ------------------------------------------------------------
    always_comb
    begin
        // Slot 3 of bits 0 and 1 has no source; tied low so the pad shows a known level
        alt_value[p7m_pkg::PIN_BIT0] = {1'b0, timer6_toggle_out, timer3_toggle_out,
            gpio_out[0]}; // R5
        alt_value[p7m_pkg::PIN_BIT1] = {1'b0, can_node4_tx_alt, programmable_clock_out,
            gpio_out[1]}; // R9
        alt_value[p7m_pkg::PIN_BIT2] = {can_node5_tx, can_node4_tx, analog_mux_ctrl_bit0,
            gpio_out[2]}; // R3
        alt_value[p7m_pkg::PIN_BIT3] = {serial_ch0_data_out, serial_ch1_data_out,
            analog_mux_ctrl_bit1, gpio_out[3]}; // R7
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [3:0] sel;
        sel = p7m_pkg::SEL_RESET;
        next_state = state;
        // Three-stage synchronisers; only stages 2 and 3 are compared
        next_state.sync1 = pin_in;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        // Level moves only when stages 2 and 3 agree, so one-cycle glitches drop out
        for (int i = 0; i < p7m_pkg::PIN_COUNT; i++)
        begin
            if (state.sync2[i] == state.sync3[i])
            begin
                next_state.level[i] = state.sync3[i];
            end
        end
        // Debug-reset and test-enable pins use the same filter as the pads
        next_state.trst_s1 = {factory_test_enable, debug_reset_pin};
        next_state.trst_s2 = state.trst_s1;
        next_state.trst_s3 = state.trst_s2;
        next_state.trst_fill = {state.trst_fill[1:0], 1'b1};
        for (int i = 0; i < 2; i++)
        begin
            if (state.trst_s2[i] == state.trst_s3[i])
            begin
                next_state.trst_lvl[i] = state.trst_s3[i];
            end
        end
        // Debug activation decided once, first settled sample after reset
        // Stages still hold reset zeros at first, so wait for the fill marker
        unique case (state.dbg)
            p7m_pkg::DBG_WAIT:
            begin
                if (state.trst_fill[2] && state.trst_s2[0] == state.trst_s3[0])
                begin
                    next_state.dbg = state.trst_s3[0] ? p7m_pkg::DBG_ACTIVE
                        : p7m_pkg::DBG_INACTIVE; // R10
                end
            end
            p7m_pkg::DBG_INACTIVE: next_state.dbg = p7m_pkg::DBG_INACTIVE;
            p7m_pkg::DBG_ACTIVE: next_state.dbg = p7m_pkg::DBG_ACTIVE;
            default: next_state.dbg = p7m_pkg::DBG_WAIT;
        endcase
        // Output selection per pin; registered so data outputs are clean
        for (int i = 0; i < p7m_pkg::PIN_COUNT; i++)
        begin
            sel = output_select_field[i*p7m_pkg::SEL_WIDTH +: p7m_pkg::SEL_WIDTH];
            next_state.out[i] = alt_value[i][alt_index(sel)]; // R1
            next_state.oe_n[i] = ~sel[p7m_pkg::SEL_ENABLE_BIT]; // R15
        end
        // Debug data out owns bit 0 only while the debug system is active
        if (state.dbg == p7m_pkg::DBG_ACTIVE && debug_tdo_en)
        begin
            next_state.out[p7m_pkg::PIN_BIT0] = debug_tdo; // R2
            next_state.oe_n[p7m_pkg::PIN_BIT0] = 1'b0; // R2
        end
    end

    // ------------------------------------------------------------
    // State register; pins float at reset
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Filters clear and pads float while the power-on reset pin is low
            state <= '{sync1: 4'h0, sync2: 4'h0, sync3: 4'h0, level: 4'h0,
                trst_s1: 2'h0, trst_s2: 2'h0, trst_s3: 2'h0, trst_lvl: 2'h0,
                trst_fill: 3'h0,
                dbg: p7m_pkg::DBG_WAIT,
                out: 4'h0,
                oe_n: 4'hf};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    // Registered so a select change never glitches the pad
    assign pin_out = state.out;
    assign pin_oe_n = state.oe_n;

    // ------------------------------------------------------------
    // Input routes; never depend on output selection
    // ------------------------------------------------------------
    // Every consumer except the gated scan inputs sees the filtered level, even while the pin is driven
    assign gpio_in = state.level; // R14
    assign ext_service_req2_in1 = state.level[p7m_pkg::PIN_BIT0]; // R6
    assign can_node4_rx_b = state.level[p7m_pkg::PIN_BIT0]; // R6
    assign capture_unit_trap_in = state.level[p7m_pkg::PIN_BIT1]; // R9
    assign debug_break_in = state.level[p7m_pkg::PIN_BIT1]; // R9
    assign capture_unit_pos_in0 = state.level[p7m_pkg::PIN_BIT2]; // R4
    // Scan inputs read zero unless scan position C was chosen at start-up
    assign scan_tdi = scan_pos_c_sel & state.level[p7m_pkg::PIN_BIT2]; // R4
    assign capture_unit_pos_in1 = state.level[p7m_pkg::PIN_BIT3]; // R8
    assign serial_ch1_data_in_f = state.level[p7m_pkg::PIN_BIT3]; // R8
    assign scan_tms = scan_pos_c_sel & state.level[p7m_pkg::PIN_BIT3]; // R8

    // ------------------------------------------------------------
    // Debug and test status
    // ------------------------------------------------------------
    // Latched at start-up; a later debug-reset pin level cannot change it
    assign debug_active = (state.dbg == p7m_pkg::DBG_ACTIVE); // R10
    // Low level on debug reset pin resets debug logic (relies on outside pulse)
    assign debug_reset_req = (state.dbg == p7m_pkg::DBG_ACTIVE) & ~state.trst_lvl[0]; // R11
    // Test enable resets to 0 in the filter, so test mode shows until settled high
    assign factory_test_mode = ~state.trst_lvl[1]; // R13
endmodule
`default_nettype wire

// ### p7m_pin_select_assertions.sv
// Purpose: Port checks for the port 7 pin selector
// Assumes: Inputs held 5 edges have passed the filters
// Notes: Chosen outputs follow their source one edge later
`timescale 1ns/1ps
`default_nettype none
module p7m_pin_select_checker
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [15:0] output_select_field,
    input wire logic timer3_toggle_out,
    input wire logic programmable_clock_out,
    input wire logic can_node4_tx,
    input wire logic serial_ch0_data_out,
    input wire logic debug_tdo,
    input wire logic debug_tdo_en,
    input wire logic [3:0] pin_in,
    input wire logic factory_test_enable,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic capture_unit_pos_in0,
    input wire logic debug_active,
    input wire logic factory_test_mode
);
    logic [15:0] s;
    logic hw;
    // Short aliases keep the properties readable
    assign s = output_select_field;
    assign hw = debug_active && debug_tdo_en;
    // One domain: shared clock and reset for every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    undriven_pin_a: assert property (!s[11] |=> pin_oe_n[2])
        else $error("pin 2 driven");
    bit2_can4_a: assert property (s[11] && s[9:8] == 2'h2 |=>
        pin_out[2] == $past(can_node4_tx)) else $error("pin 2 not CAN 4");
    bit0_timer3_a: assert property (s[3] && s[1:0] == 2'h1 && !hw |=>
        pin_out[0] == $past(timer3_toggle_out)) else $error("pin 0 not timer 3");
    bit3_serial0_a: assert property (s[15] && s[13:12] == 2'h3 |=>
        pin_out[3] == $past(serial_ch0_data_out)) else $error("pin 3 not serial 0");
    bit1_clock_a: assert property (s[7] && s[5:4] == 2'h1 |=>
        pin_out[1] == $past(programmable_clock_out)) else $error("pin 1 not clock");
    hw_owned_a: assert property (hw |=>
        !pin_oe_n[0] && pin_out[0] == $past(debug_tdo)) else $error("pin 0 not debug");
    pos_input_a: assert property ($stable(pin_in[2]) [*5] |->
        capture_unit_pos_in0 == pin_in[2]) else $error("position input stale");
    test_mode_a: assert property ($stable(factory_test_enable) [*5] |->
        factory_test_mode == !factory_test_enable) else $error("test mode wrong");
    debug_latch_a: assert property (debug_active |=> debug_active)
        else $error("debug enable dropped");
    // Main scenarios reached
    cover property (hw);
    cover property (factory_test_mode);
    cover property (s[11] && s[9:8] == 2'h3);
endmodule
bind p7m_pin_select p7m_pin_select_checker chk_i (.*);
`default_nettype wire

// ### p7m_board.sv
// Purpose: Board model closing each port 7 pin loop
// Assumes: No pull device on these pins
// Notes: A pin released by both the device and the external driver toggles so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module p7m_board
(
    input wire logic clock,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] pin_in
);
    logic [3:0] held = 4'h0;
    // Floating level flips every cycle
    always_ff @(posedge clock)
        held <= ~pin_in;
    // Device drive wins, then the external driver, else floating
    always_comb
        for (int i = 0; i < 4; i++)
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : held[i]);
endmodule
`default_nettype wire

// ### p7m_pin_select_bench.sv
// Purpose: Self-checking bench for the port 7 pin selector
// Assumes: Board model feeds every pin back
// Notes: A second reset with the debug pin high starts debug
`timescale 1ns/1ps
`default_nettype none
module p7m_pin_select_bench;
    logic clock = 0;
    logic arst_n = 0;
    logic [15:0] output_select_field = 16'h0000;
    logic [3:0] gpio_out = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
    logic [3:0] pin_in, pin_out, pin_oe_n, gpio_in;
    logic timer3_toggle_out = 0, timer6_toggle_out = 0, programmable_clock_out = 0;
    logic can_node4_tx = 0, can_node4_tx_alt = 0, can_node5_tx = 0, debug_tdo = 0;
    logic analog_mux_ctrl_bit0 = 0, analog_mux_ctrl_bit1 = 0, debug_tdo_en = 0;
    logic serial_ch1_data_out = 0, serial_ch0_data_out = 0, scan_pos_c_sel = 0;
    logic debug_reset_pin = 0, factory_test_enable = 1;
    logic ext_service_req2_in1, can_node4_rx_b, capture_unit_pos_in0, capture_unit_pos_in1;
    logic capture_unit_trap_in, debug_break_in, serial_ch1_data_in_f, scan_tdi, scan_tms;
    logic debug_active, debug_reset_req, factory_test_mode;
    int n_fail = 0, cmp_count = 0;
    p7m_pin_select uut (.*);
    p7m_board board (.*);
    // 200 MHz clock
    always #2.5 clock = ~clock;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (e !== g)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic do_reset(logic dbg);
        @(posedge clock);
        arst_n <= 0;
        debug_reset_pin <= dbg;
        repeat (16) @(posedge clock);
        arst_n <= 1;
        tick(8);
    endtask
    // All four alternate codes on every pin, x bit set on pins 1 and 3
    task automatic t_outsel;
        logic [13:0] m;
        for (int a = 0; a < 4; a++)
            for (int v = 0; v < 2; v++)
            begin
                m = 14'h3C00 >> (4 * a);
                @(posedge clock);
                output_select_field <= {2'b11, a[1:0], 2'b10, a[1:0], 2'b11, a[1:0], 2'b10, a[1:0]};
                {gpio_out, timer3_toggle_out, programmable_clock_out, analog_mux_ctrl_bit0,
                    analog_mux_ctrl_bit1, timer6_toggle_out, can_node4_tx_alt, can_node4_tx,
                    serial_ch1_data_out, can_node5_tx, serial_ch0_data_out} <= v[0] ? m : ~m;
                tick(2);
                chk("pin_out", (a == 3) ? {v[0], v[0], 2'b00} : {4{v[0]}}, pin_out);
                chk("pin_oe_n", 4'h0, pin_oe_n);
            end
    endtask
    // Input routing with pins released or driven by the device
    task automatic route(logic [15:0] s, logic [3:0] e, logic [3:0] v, logic c, logic [3:0] oe,
        logic [8:0] r);
        @(posedge clock);
        output_select_field <= s;
        ext_en <= e;
        ext_val <= v;
        gpio_out <= v;
        scan_pos_c_sel <= c;
        tick(8);
        chk("pin_oe_n", oe, pin_oe_n);
        chk("gpio_in", v, gpio_in);
        chk("routed", r, {ext_service_req2_in1, can_node4_rx_b, capture_unit_trap_in,
            debug_break_in, capture_unit_pos_in0, capture_unit_pos_in1, serial_ch1_data_in_f,
            scan_tdi, scan_tms});
    endtask
    task automatic t_test_mode;
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clock);
            factory_test_enable <= v[0];
            tick(8);
            chk("factory_test_mode", !v[0], factory_test_mode);
        end
    endtask
    task automatic t_debug;
        chk("debug_active", 0, debug_active);
        @(posedge clock);
        output_select_field <= 16'h0000;
        debug_tdo_en <= 1;
        debug_tdo <= 1;
        tick(2);
        chk("pin_oe_n", 1, pin_oe_n[0]);
        do_reset(1);
        chk("debug_active", 1, debug_active);
        chk("debug_reset_req", 0, debug_reset_req);
        @(posedge clock);
        debug_reset_pin <= 0;
        output_select_field <= 16'h0000;
        debug_tdo_en <= 1;
        debug_tdo <= 1;
        tick(8);
        chk("debug_reset_req", 1, debug_reset_req);
        chk("pin0", 2'b01, {pin_oe_n[0], pin_out[0]});
    endtask
    task automatic finish_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        do_reset(0);
        t_outsel();
        route(16'h7430, 4'hF, 4'hE, 1, 4'hF, 9'b001111111);
        route(16'h8888, 4'h0, 4'h5, 0, 4'h0, 9'b110010000);
        t_test_mode();
        t_debug();
        finish_test();
    end
    // Run needs about 120 cycles; far longer means a hang
    initial
    begin
        #20us;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
